// [rtl/lbip_pkg.sv]
// Package for the local bus inbound port: shared types and constants.
// Assumes one local clock domain at 100 MHz; no software-visible registers.
package lbip_pkg;

   // Data bus and word widths
   localparam int DATA_W      = 16;                     // Half-word lanes on the DDR bus
   localparam int WORD_W      = 32;                     // Whole word moved per local clock
   localparam int NUM_VC      = 2;                      // Virtual channels
   localparam int LEN_W       = 8;                      // Packet length field, in words

   // Clock figures
   localparam int CLK_PERIOD_NS = 10;                   // Local clock period
   localparam int MAX_MTPS      = 400;                  // Data lane ceiling, mega-transfers per second
   localparam int SYNC_STAGES   = 2;                    // Flip-flops on every asynchronous input

   // Reset values
   localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
   localparam logic [LEN_W-1:0]  LEN_RST  = 8'h00;
   localparam logic [1:0]        SYNC_RST = 2'h0;

   // Packet kinds carried inbound
   typedef enum logic [1:0]
   {
      LBIP_PKT_TGT_WRITE = 2'h0,                        // Target write from the link
      LBIP_PKT_TGT_READ  = 2'h1,                        // Target read request from the link
      LBIP_PKT_MST_CPL   = 2'h2                         // Completion of a local read
   } lbip_kind_t;

   // Window a packet targets on the link side
   typedef enum logic [1:0]
   {
      LBIP_WIN_MEM0 = 2'h0,                             // First local memory window
      LBIP_WIN_MEM1 = 2'h1,                             // Second local memory window
      LBIP_WIN_CFG  = 2'h2,                             // Configuration space
      LBIP_WIN_REG  = 2'h3                              // Internal register window
   } lbip_win_t;

   // Packet descriptor offered by the link core
   typedef struct packed
   {
      lbip_kind_t       kind;                           // Packet type
      lbip_win_t        win;                            // Target window
      logic             vc;                             // Virtual channel
      logic [LEN_W-1:0] len;                            // Words in packet, header included, at least 1
   } lbip_desc_t;

   // Pins driven toward the attached logic
   typedef struct packed
   {
      logic              fclk;                          // Forwarded data clock
      logic [DATA_W-1:0] data;                          // DDR data lanes
      logic              frame;                         // Frame strobe, DDR timed
      logic              valid;                         // Valid strobe, DDR timed
   } lbip_ddr_t;

endpackage : lbip_pkg

// [rtl/lbip_ddr_launch.sv]
// DDR launcher: turns one 32-bit word per local clock into two half-words.
// Assumes the caller registers word, frame and valid on the local clock.
`timescale 1ns/1ps

module lbip_ddr_launch
(
   input  wire logic                        i_clk,       // Local clock
   input  wire logic                        i_rst,       // Synchronous-release reset, active high inside
   input  wire logic [lbip_pkg::WORD_W-1:0] i_word,      // Word to send
   input  wire logic                        i_frame,     // Frame for this word
   input  wire logic                        i_valid,     // Valid for this word
   output      lbip_pkg::lbip_ddr_t         o_ddr        // Pins
);

   ////////////////////////////////////////////////////////////////////////////
   // Falling-edge copy of the upper half-word
   logic [lbip_pkg::DATA_W-1:0] hi_half;                 // Upper half held for the low phase

   // Capture on the falling edge so the half-word changes with the forwarded clock edge
   always_ff @(negedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         hi_half <= '0;
      else
         hi_half <= i_word[lbip_pkg::WORD_W-1:lbip_pkg::DATA_W];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output mux: low half in the high phase, high half in the low phase
   always_comb
   begin
      o_ddr.fclk  = i_clk & ~i_rst;
      o_ddr.data  = i_clk ? i_word[lbip_pkg::DATA_W-1:0] : hi_half;
      o_ddr.frame = i_frame;
      o_ddr.valid = i_valid;
   end

endmodule : lbip_ddr_launch

// [rtl/lbip_inbound_port.sv]
// Inbound port of the local bus: sends link packets to the attached logic.
// Assumes a link core offering descriptors and words on the local clock,
// and attached logic whose ready inputs are asynchronous.
`timescale 1ns/1ps

module lbip_inbound_port
(
   input  wire logic                                i_clk,         // Local clock, 100 MHz
   input  wire logic                                i_rst_n,       // Reset, active low, asynchronous
   // Link core side
   input  wire logic                                i_desc_valid,  // Descriptor on offer
   input  wire lbip_pkg::lbip_desc_t                i_desc,        // Descriptor of next packet
   output      logic                                o_desc_ready,  // Descriptor taken this cycle
   input  wire logic [lbip_pkg::WORD_W-1:0]         i_word,        // Current packet word
   output      logic                                o_word_take,   // Word consumed this cycle
   output      logic                                o_int_access,  // Pulse: packet kept internal
   // Attached logic side
   input  wire logic                                i_buf_ready,   // Inbound buffer ready, async
   input  wire logic [lbip_pkg::NUM_VC-1:0]         i_wr_ready,    // Write ready per channel, async
   output      logic [lbip_pkg::NUM_VC-1:0]         o_wr_req,      // Write request per channel
   output      lbip_pkg::lbip_ddr_t                 o_ddr          // Inbound DDR pins
);

   ////////////////////////////////////////////////////////////////////////////
   // Derived figures
   localparam int MIN_PERIOD_NS = 2000 / lbip_pkg::MAX_MTPS;      // Two transfers per clock period
   localparam int PERIOD_OK     = (lbip_pkg::CLK_PERIOD_NS >= MIN_PERIOD_NS) ? 1 : 0;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release: two flip-flops, then everyone uses rst
   logic [1:0] rst_pipe;                                  // Release shifter
   logic       rst;                                       // Internal reset, active high

   // Assert at once, release after two edges
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         rst_pipe <= lbip_pkg::SYNC_RST;
      else
         rst_pipe <= {rst_pipe[0], 1'b1};
   end

   assign rst = ~rst_pipe[1];

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers; the first stage is read only by the second
   logic                        buf_rdy_s1;               // First stage, buffer ready
   logic                        buf_rdy;                  // Synchronised buffer ready
   logic [lbip_pkg::NUM_VC-1:0] wr_rdy_s1;                // First stage, write ready
   logic [lbip_pkg::NUM_VC-1:0] wr_rdy;                   // Synchronised write ready

   // Two flip-flops per asynchronous control input
   always_ff @(posedge i_clk or posedge rst)
   begin
      if (rst)
      begin
         buf_rdy_s1 <= 1'b0;
         buf_rdy    <= 1'b0;
         wr_rdy_s1  <= '0;
         wr_rdy     <= '0;
      end
      else
      begin
         buf_rdy_s1 <= i_buf_ready;
         buf_rdy    <= buf_rdy_s1;
         wr_rdy_s1  <= i_wr_ready;
         wr_rdy     <= wr_rdy_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   // True for packets that leave over the bus rather than stay internal
   function automatic logic goes_out(input lbip_pkg::lbip_desc_t d);
      goes_out = (d.win == lbip_pkg::LBIP_WIN_MEM0) || (d.win == lbip_pkg::LBIP_WIN_MEM1)
                 || (d.kind == lbip_pkg::LBIP_PKT_MST_CPL);
   endfunction : goes_out

   // One-hot channel mask
   function automatic logic [lbip_pkg::NUM_VC-1:0] vc_mask(input logic vc);
      vc_mask = vc ? 2'h2 : 2'h1;
   endfunction : vc_mask

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   typedef enum {ST_IDLE, ST_WAIT_WR, ST_SEND} lbip_state_t;

   lbip_state_t               state;                      // Current state
   lbip_state_t               next_state;                 // Next state
   lbip_pkg::lbip_desc_t      cur;                        // Packet in flight
   logic [lbip_pkg::LEN_W-1:0] left;                      // Words still to send
   logic                      is_write;                   // Current packet is a memory write
   logic                      send;                       // A word leaves this cycle
   logic                      start_ok;                   // Offered packet may start now
   logic                      offer_write;                // Offered packet is a memory write

   assign offer_write = (i_desc.kind == lbip_pkg::LBIP_PKT_TGT_WRITE) && goes_out(i_desc);
   // Early ready counts: a write whose channel is already ready starts at once
   assign start_ok    = !offer_write || ((wr_rdy & vc_mask(i_desc.vc)) != '0);
   assign is_write    = (cur.kind == lbip_pkg::LBIP_PKT_TGT_WRITE);
   // Words move only while the synchronised buffer ready is high
   assign send        = (state == ST_SEND) && buf_rdy;

   // Next-state logic
   always_comb
   begin
      next_state   = state;
      o_desc_ready = 1'b0;
      case (state)
         ST_IDLE:
         begin
            if (i_desc_valid && !goes_out(i_desc))
               o_desc_ready = 1'b1;
            else if (i_desc_valid && start_ok)
            begin
               o_desc_ready = 1'b1;
               next_state   = ST_SEND;
            end
            else if (i_desc_valid)
            begin
               o_desc_ready = 1'b1;
               next_state   = ST_WAIT_WR;
            end
         end
         ST_WAIT_WR:
         begin
            if ((wr_rdy & vc_mask(cur.vc)) != '0)
               next_state = ST_SEND;
         end
         ST_SEND:
         begin
            if (send && (left == 8'h01))
               next_state = ST_IDLE;
         end
         default:
            next_state = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge i_clk or posedge rst)
   begin
      if (rst)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // Descriptor capture and word count
   always_ff @(posedge i_clk or posedge rst)
   begin
      if (rst)
      begin
         cur  <= '0;
         left <= lbip_pkg::LEN_RST;
      end
      else if (o_desc_ready && goes_out(i_desc))
      begin
         cur  <= i_desc;
         left <= (i_desc.len == lbip_pkg::LEN_RST) ? 8'h01 : i_desc.len; // Zero length treated as one
      end
      else if (send)
         left <= left - 8'h01;
   end

   // Internal accesses are reported and never reach the pins
   always_ff @(posedge i_clk or posedge rst)
   begin
      if (rst)
         o_int_access <= 1'b0;
      else
         o_int_access <= o_desc_ready && !goes_out(i_desc);
   end

   assign o_word_take = send;

   ////////////////////////////////////////////////////////////////////////////
   // Write request per channel, registered
   // Held from acceptance of a memory write until its packet finishes
   always_ff @(posedge i_clk or posedge rst)
   begin
      if (rst)
         o_wr_req <= '0;
      else if (next_state == ST_IDLE)
         o_wr_req <= '0;
      else if (is_write || (o_desc_ready && offer_write))
         o_wr_req <= (o_desc_ready && offer_write) ? vc_mask(i_desc.vc) : vc_mask(cur.vc);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered word, frame and valid toward the launcher
   logic [lbip_pkg::WORD_W-1:0] out_word;                 // Word on the lanes
   logic                        out_frame;                // Frame for that word
   logic                        out_valid;                // Valid for that word

   // Frame rises with the first word and falls for the last one;
   // valid stays low while paused, so the frame cycle shows no data
   always_ff @(posedge i_clk or posedge rst)
   begin
      if (rst)
      begin
         out_word  <= lbip_pkg::WORD_RST;
         out_frame <= 1'b0;
         out_valid <= 1'b0;
      end
      else
      begin
         out_valid <= send;
         if (send)
         begin
            out_word  <= i_word;
            out_frame <= (left != 8'h01);
         end
         else if (state != ST_SEND)
            out_frame <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // DDR launcher; the lanes only ever move whole words
   lbip_ddr_launch u_launch
   (
      .i_clk   (i_clk),
      .i_rst   (rst),
      .i_word  (out_word),
      .i_frame (out_frame),
      .i_valid (out_valid & PERIOD_OK[0]),
      .o_ddr   (o_ddr)
   );

   // The outbound quarter-period sampling clock belongs to the receive path,
   // which is not part of this block.

endmodule : lbip_inbound_port

// [sim/lbip_inbound_chk.sv]
// Checker for the inbound port: timing relations between its pins.
// Assumes one local clock; bound into every inbound port instance.
`timescale 1ns/1ps
module lbip_inbound_chk
(
   input wire logic                        i_clk,
   input wire logic                        i_rst_n,
   input wire logic                        i_desc_valid,
   input wire lbip_pkg::lbip_desc_t        i_desc,
   input wire logic                        o_desc_ready,
   input wire logic [lbip_pkg::WORD_W-1:0] i_word,
   input wire logic                        o_word_take,
   input wire logic                        o_int_access,
   input wire logic                        i_buf_ready,
   input wire logic [lbip_pkg::NUM_VC-1:0] i_wr_ready,
   input wire logic [lbip_pkg::NUM_VC-1:0] o_wr_req,
   input wire lbip_pkg::lbip_ddr_t         o_ddr
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////////////////////
   // Ready low long enough to cross the synchroniser and output register
   sequence s_paused;
      !i_buf_ready [*4];
   endsequence
   // Last word goes out with frame already low
   sequence s_last_word;
      o_ddr.valid && !o_ddr.frame;
   endsequence
   rst_quiet_a: assert property (disable iff (1'b0) !i_rst_n |->
      !o_ddr.fclk && !o_ddr.frame && !o_ddr.valid && o_wr_req == 2'h0) else $error("output active in reset");
   start_idle_a: assert property ($rose(i_rst_n) |-> !o_ddr.valid [*3]) else $error("valid after reset");
   req_onehot_a: assert property ($onehot0(o_wr_req)) else $error("two write requests");
   req_hold_a: assert property ($fell(|o_wr_req) |-> s_last_word) else $error("request dropped early");
   frame_end_a: assert property ($fell(o_ddr.frame) && $past(i_buf_ready, 2) && $past(i_buf_ready, 3)
      |-> s_last_word) else $error("frame not released before last word");
   pause_stop_a: assert property (s_paused |-> !o_ddr.valid) else $error("valid while paused");
   resume_lag_a: assert property (s_paused ##1 i_buf_ready |-> !o_ddr.valid [*3]) else $error("resume too fast");
   drop_cause_a: assert property ($fell(o_ddr.valid) && o_ddr.frame |->
      !$past(i_buf_ready, 2) || !$past(i_buf_ready, 3) || !$past(i_buf_ready, 4)) else $error("valid dropped");
   wr_gate_a: assert property ($rose(o_ddr.frame) && |o_wr_req |->
      |(o_wr_req & ($past(i_wr_ready, 2) | $past(i_wr_ready, 3)))) else $error("write before ready");
   int_quiet_a: assert property (o_int_access |-> !o_ddr.frame && o_wr_req == 2'h0) else $error("internal shown");
   idle_take_a: assert property (o_desc_ready |-> o_wr_req == 2'h0 && !o_ddr.frame) else $error("overlap");
endmodule : lbip_inbound_chk

bind lbip_inbound_port lbip_inbound_chk lbip_inbound_chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_desc_valid(i_desc_valid), .i_desc(i_desc), .o_desc_ready(o_desc_ready), .i_word(i_word),
   .o_word_take(o_word_take), .o_int_access(o_int_access), .i_buf_ready(i_buf_ready),
   .i_wr_ready(i_wr_ready), .o_wr_req(o_wr_req), .o_ddr(o_ddr));

// [sim/lbip_fpga_model.sv]
// Model of the attached logic: answers ready lines, captures inbound words.
// Assumes the bench commands stalls through i_wr_en and i_buf_en.
`timescale 1ns/1ps
module lbip_fpga_model
(
   input  wire logic                        i_clk,
   input  wire logic [lbip_pkg::NUM_VC-1:0] i_wr_en,     // Channels able to take writes
   input  wire logic                        i_buf_en,    // Buffer has room
   input  wire logic [lbip_pkg::NUM_VC-1:0] i_wr_req,
   input  wire lbip_pkg::lbip_ddr_t         i_ddr,
   output      logic                        o_buf_ready,
   output      logic [lbip_pkg::NUM_VC-1:0] o_wr_ready
);
   logic [31:0] rx_word [$];   // Words seen with valid
   logic        rx_frame [$];  // Frame seen with each word
   logic [15:0] lo_half;
   logic        fr;
   logic        vl = 1'b0;
   initial o_buf_ready = 1'b0;
   initial o_wr_ready = 2'h0;
   ////////////////////////////////////////////////////////////////////////////
   // Ready lines move just after an edge; raised early, before any request
   always @(posedge i_clk)
   begin
      o_buf_ready <= i_buf_en;
      o_wr_ready <= i_wr_en;
   end
   // Low half rides the high phase of the forwarded clock
   always @(posedge i_ddr.fclk)
   begin
      #2;
      lo_half = i_ddr.data;
      fr = i_ddr.frame;
      vl = i_ddr.valid;
   end
   // One strobe value qualifies the whole word
   always @(negedge i_ddr.fclk)
   begin
      #2;
      if (vl)
      begin
         rx_word.push_back({i_ddr.data, lo_half});
         rx_frame.push_back(fr);
      end
   end
endmodule : lbip_fpga_model

// [sim/lbip_inbound_port_tb.sv]
// Testbench for the inbound port: link-core driver, scenarios, verdict.
// Assumes the attached-logic model captures words off the DDR pins.
`timescale 1ns/1ps
module lbip_inbound_port_tb;
   logic                 i_clk = 1'b0;
   logic                 i_rst_n = 1'b1;
   logic                 i_desc_valid = 1'b0;
   lbip_pkg::lbip_desc_t i_desc = '0;
   logic [31:0]          base = 32'h0;
   logic [31:0]          i_word;
   logic [7:0]           widx = 8'h00;
   logic [1:0]           wr_en = 2'h3;
   logic                 buf_en = 1'b1;
   logic                 o_desc_ready, o_word_take, o_int_access, buf_ready, seen;
   logic [1:0]           wr_ready, o_wr_req;
   lbip_pkg::lbip_ddr_t  o_ddr;
   int                   errors = 0, samples_checked = 0, cycles = 0, cnt;
   always #5 i_clk = ~i_clk;
   assign i_word = base + {24'h0, widx};
   // Next word is offered as soon as the current one is taken
   always @(posedge i_clk) if (o_word_take) widx <= widx + 8'h01;
   lbip_inbound_port lbip_inbound_port_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_desc_valid(i_desc_valid),
      .i_desc(i_desc), .o_desc_ready(o_desc_ready), .i_word(i_word), .o_word_take(o_word_take),
      .o_int_access(o_int_access), .i_buf_ready(buf_ready), .i_wr_ready(wr_ready), .o_wr_req(o_wr_req),
      .o_ddr(o_ddr));
   lbip_fpga_model lbip_fpga_model_i (.i_clk(i_clk), .i_wr_en(wr_en), .i_buf_en(buf_en), .i_wr_req(o_wr_req),
      .i_ddr(o_ddr), .o_buf_ready(buf_ready), .o_wr_ready(wr_ready));
   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task give_verdict;
      if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   // Offer one descriptor and hold it until taken; called just after an edge
   task send(input logic [1:0] k, input logic [1:0] w, input logic v, input logic [7:0] n, input logic [31:0] b);
      int t;
      lbip_fpga_model_i.rx_word.delete();
      lbip_fpga_model_i.rx_frame.delete();
      base <= b;
      widx <= 8'h00;
      i_desc <= {k, w, v, n};
      i_desc_valid <= 1'b1;
      t = 0;
      do @(negedge i_clk); while (!o_desc_ready && ++t < 200);
      @(posedge i_clk);
      i_desc_valid <= 1'b0;
   endtask : send
   // Wait for n words, let strays show, then compare words and frames
   task expect_words(input logic [31:0] b, input int n);
      int t;
      t = 0;
      while (lbip_fpga_model_i.rx_word.size() < n && t++ < 300) @(posedge i_clk);
      repeat (6) @(posedge i_clk);
      chk(32'(lbip_fpga_model_i.rx_word.size()), 32'(n));
      for (int k = 0; k < n && k < lbip_fpga_model_i.rx_word.size(); k++)
      begin
         chk(lbip_fpga_model_i.rx_word[k], b + 32'(k));
         chk({31'h0, lbip_fpga_model_i.rx_frame[k]}, 32'(k < n - 1));
      end
   endtask : expect_words
   // Outputs quiet while reset is held
   task t_reset;
      chk({28'h0, o_ddr.fclk, o_ddr.frame, o_ddr.valid, |o_wr_req}, 32'h0);
   endtask : t_reset
   // Writes on both channels with ready raised early
   task t_write;
      send(2'h0, 2'h0, 1'b0, 8'h03, 32'hA000_1000);
      repeat (2) @(negedge i_clk);
      chk({30'h0, o_wr_req}, 32'h1);
      expect_words(32'hA000_1000, 3);
      send(2'h0, 2'h1, 1'b1, 8'h03, 32'hB000_2000);
      repeat (2) @(negedge i_clk);
      chk({30'h0, o_wr_req}, 32'h2);
      expect_words(32'hB000_2000, 3);
   endtask : t_write
   // A write waits while its own channel is not ready
   task t_stall;
      wr_en <= 2'h1;
      // Let the lowered ready cross the model register and both synchroniser stages first
      repeat (4) @(posedge i_clk);
      send(2'h0, 2'h0, 1'b1, 8'h02, 32'hC000_3000);
      repeat (12) @(posedge i_clk);
      chk(32'(lbip_fpga_model_i.rx_word.size()), 32'h0);
      chk({30'h0, o_wr_req}, 32'h2);
      wr_en <= 2'h3;
      expect_words(32'hC000_3000, 2);
   endtask : t_stall
   // Read requests and completions need no write ready
   task t_kinds;
      wr_en <= 2'h0;
      for (int i = 0; i < 3; i++)
      begin
         send(i == 0 ? 2'h1 : 2'h2, 2'(i), 1'(i), 8'h02, 32'hD000_0000 + 32'(i << 8));
         expect_words(32'hD000_0000 + 32'(i << 8), 2);
      end
      wr_en <= 2'h3;
   endtask : t_kinds
   // A target write to the configuration window and a target read to the register window stay off the pins
   task t_internal;
      for (int w = 2; w < 4; w++)
      begin
         send(2'(w - 2), 2'(w), 1'b0, 8'h02, 32'hE000_0000);
         seen = 1'b0;
         repeat (6) @(negedge i_clk) seen |= o_int_access;
         chk({31'h0, seen}, 32'h1);
         expect_words(32'hE000_0000, 0);
      end
   endtask : t_internal
   // Buffer ready dropped mid-packet halts and then resumes the stream
   task t_pause;
      send(2'h0, 2'h0, 1'b0, 8'h0A, 32'hF000_4000);
      repeat (2) @(posedge i_clk);
      buf_en <= 1'b0;
      repeat (6) @(posedge i_clk);
      cnt = lbip_fpga_model_i.rx_word.size();
      repeat (6) @(posedge i_clk);
      chk(32'(lbip_fpga_model_i.rx_word.size()), 32'(cnt));
      buf_en <= 1'b1;
      expect_words(32'hF000_4000, 10);
   endtask : t_pause
   ////////////////////////////////////////////////////////////////////////////
   // Hang guard; the whole run needs well under a thousand cycles
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         give_verdict();
      end
   end
   initial
   begin
      // A real falling edge, so the asynchronous reset acts before the first clock edge
      #1 i_rst_n = 1'b0;
      repeat (2) @(posedge i_clk);
      t_reset();
      @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      t_write();
      t_stall();
      t_kinds();
      t_internal();
      t_pause();
      give_verdict();
   end
endmodule : lbip_inbound_port_tb
